// *** logic/ipe_pkg.sv ***
/*
  Shared constants and carriers for the interrupt priority, edge select
  and status word block.
  Assumes one CPU clock domain and a synchronous active-high reset.
*/
package ipe_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 24;
  localparam int NUM_EXT = 7;
  localparam int SRC_W = 5;
  localparam int SYNC_FILL = 3;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_PRIORITY_FLAGS_0_LOW = 16'hFFE8;
  localparam logic [15:0] ADDR_PRIORITY_FLAGS_0_HIGH = 16'hFFE9;
  localparam logic [15:0] ADDR_PRIORITY_FLAGS_1_LOW = 16'hFFEA;
  localparam logic [15:0] ADDR_PRIORITY_FLAGS_1_HIGH = 16'hFFEB;
  localparam logic [15:0] ADDR_EGP = 16'hFF48;
  localparam logic [15:0] ADDR_EGN = 16'hFF49;
  localparam logic [15:0] ADDR_PSW = 16'hFF1E;

  // ----------------------------------------------------------------
  // Reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PR = 8'hFF;
  localparam logic [6:0] RST_EG = 7'h00;
  localparam logic [7:0] RST_PSW = 8'h02;
  localparam int PSW_IE_BIT = 7;
  localparam int PSW_ISP_BIT = 1;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef logic [SRC_W-1:0] ipe_src_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic word;
    logic bit_op;
    logic [2:0] bit_idx;
    logic bit_val;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ipe_sfr_req_s;

  typedef struct packed {
    logic ack;
    logic software_break_instr;
    logic ei;
    logic di;
    logic restore;
    logic [7:0] stack_psw;
  } ipe_core_s;

  typedef struct packed {
    logic valid;
    logic prio;
    ipe_src_t src;
  } ipe_irq_s;

endpackage

// *** logic/ipe_edge_detect.sv ***
/*
  Synchronises the external interrupt pins and detects the selected edges.
  Assumes asynchronous pins and rise/fall selects from the CPU clock domain.
*/
`timescale 1ns/1ps
module ipe_edge_detect #(
  parameter int N = 7
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [N-1:0] i_pin,
  input wire logic [N-1:0] i_rise_sel,
  input wire logic [N-1:0] i_fall_sel,
  output logic [N-1:0] o_edge
);
  import ipe_pkg::*;

  logic [N-1:0] sync1;
  logic [N-1:0] sync2;
  logic [N-1:0] prev;
  logic [1:0] fill;
  logic armed;

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    sync1 <= i_pin;
    sync2 <= sync1;
    prev <= sync2;
  end

  // Holds off detection until the history stages hold real pin levels
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      fill <= 2'h0;
    end else if (!armed) begin
      fill <= fill + 2'h1;
    end
  end
  assign armed = (fill == 2'(SYNC_FILL));

  // ----------------------------------------------------------------
  // Edge select
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !armed) begin
      o_edge <= '0;
    end else begin
      o_edge <= (sync2 & ~prev & i_rise_sel) | (~sync2 & prev & i_fall_sel);
    end
  end

  property p_edge_once;
    @(posedge i_clk_sys) disable iff (i_rst) (|o_edge) |=> ((o_edge & $past(o_edge)) == '0);
  endproperty
  a_edge_once: assert property (p_edge_once) else $error("edge reported twice");

  property p_edge_selected;
    @(posedge i_clk_sys) disable iff (i_rst)
      1'b1 |=> ((o_edge & ~$past(i_rise_sel | i_fall_sel)) == '0);
  endproperty
  a_edge_selected: assert property (p_edge_selected) else $error("edge on unselected pin");

endmodule

// *** logic/ipe_ctrl.sv ***
/*
  Interrupt priority flags, external edge selection and the interrupt
  fields of the status word, with the maskable request arbiter.
  Assumes the CPU core drives the register port and acknowledge strobes
  on the CPU clock, and request and mask flags come from the same clock.
*/
// Overview of operation
// - Each maskable source has one priority flag: 0 high, 1 low.
// - Four priority bytes take bit and byte writes; pairs also as words.
// - Reset loads all priority bytes with ones, all sources low priority.
// - Per pin rise/fall pair: off, falling, rising, or both edges.
// - Edge enable bytes take bit and byte writes; reset clears them.
// - Pin 0 is P120, pins 1-4 P30-P33, pin 5 P16, pin 6 P140.
// - Status word holds global enable and in-service priority flags.
// - Status word: byte access, bit access, enable and disable instructions.
// - Vectored acknowledge or break stacks status word and clears enable.
// - Maskable acknowledge copies source priority flag into in-service flag.
// - Push stores status word; returns and pop restore it.
// - Reset sets status word to 02h, interrupts disabled.
// - Acknowledge needs request set, mask clear, enable set; low waits on high.
// - Higher programmed level wins; ties go to fixed default order.
// - In-service flag 0 while high serviced, else 1.
`timescale 1ns/1ps
module ipe_ctrl (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input ipe_pkg::ipe_sfr_req_s i_sfr,
  output logic [15:0] o_sfr_rdata,
  input ipe_pkg::ipe_core_s i_core,
  output logic [7:0] o_psw,
  input wire logic [ipe_pkg::NUM_SRC-1:0] i_req_flags,
  input wire logic [ipe_pkg::NUM_SRC-1:0] i_mask_flags,
  output ipe_pkg::ipe_irq_s o_irq,
  input wire logic [ipe_pkg::NUM_EXT-1:0] i_ext_pin,
  output logic [ipe_pkg::NUM_EXT-1:0] o_ext_edge
);
  import ipe_pkg::*;

  logic [7:0] priority_flags_0_low;
  logic [7:0] priority_flags_0_high;
  logic [7:0] priority_flags_1_low;
  logic [7:0] priority_flags_1_high;
  logic [6:0] ext_rising_edge_enable;
  logic [6:0] ext_falling_edge_enable;
  logic [7:0] psw;
  logic [NUM_SRC-1:0] pr_vec;
  logic [NUM_SRC-1:0] cand;
  logic [NUM_SRC-1:0] cand_hi;
  logic [NUM_SRC-1:0] cand_lo;
  logic [SRC_W:0] pick_hi;
  logic [SRC_W:0] pick_lo;
  ipe_irq_s next_irq;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // New value of the byte at address a under the current write
  function automatic logic [7:0] wr_byte(input ipe_sfr_req_s q, input logic [15:0] a,
                                         input logic [7:0] old);
    logic lo_hit;
    logic hi_hit;
    logic [7:0] d;
    lo_hit = q.wr && (q.addr == a);
    hi_hit = q.wr && q.word && ((q.addr + 16'h0001) == a);
    d = old;
    if (hi_hit) begin
      d = q.wdata[15:8];
    end else if (lo_hit && q.bit_op && !q.word) begin
      d[q.bit_idx] = q.bit_val;
    end else if (lo_hit) begin
      d = q.wdata[7:0];
    end
    return d;
  endfunction

  // Lowest set index, which is the highest default priority
  function automatic logic [SRC_W:0] first_set(input logic [NUM_SRC-1:0] v);
    logic [SRC_W:0] r;
    r = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, SRC_W'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] rd_byte(input logic [15:0] a, input logic [7:0] p0l,
                                         input logic [7:0] p0h, input logic [7:0] p1l,
                                         input logic [7:0] p1h, input logic [6:0] ep,
                                         input logic [6:0] en, input logic [7:0] ps);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      ADDR_PRIORITY_FLAGS_0_LOW: r = p0l;
      ADDR_PRIORITY_FLAGS_0_HIGH: r = p0h;
      ADDR_PRIORITY_FLAGS_1_LOW: r = p1l;
      ADDR_PRIORITY_FLAGS_1_HIGH: r = p1h;
      ADDR_EGP: r = {1'b0, ep};
      ADDR_EGN: r = {1'b0, en};
      ADDR_PSW: r = ps;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Priority flag registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      priority_flags_0_low <= RST_PR;
      priority_flags_0_high <= RST_PR;
      priority_flags_1_low <= RST_PR;
      priority_flags_1_high <= RST_PR;
    end else begin
      priority_flags_0_low <= wr_byte(i_sfr, ADDR_PRIORITY_FLAGS_0_LOW, priority_flags_0_low);
      priority_flags_0_high <= wr_byte(i_sfr, ADDR_PRIORITY_FLAGS_0_HIGH, priority_flags_0_high);
      priority_flags_1_low <= wr_byte(i_sfr, ADDR_PRIORITY_FLAGS_1_LOW, priority_flags_1_low);
      priority_flags_1_high <= wr_byte(i_sfr, ADDR_PRIORITY_FLAGS_1_HIGH, priority_flags_1_high);
    end
  end

  // One flag per source, index order is the default order
  assign pr_vec = {priority_flags_1_high[0], priority_flags_1_low[6:0], priority_flags_0_high, priority_flags_0_low};

  // ----------------------------------------------------------------
  // Edge enable registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ext_rising_edge_enable <= RST_EG;
      ext_falling_edge_enable <= RST_EG;
    end else begin
      ext_rising_edge_enable <= 7'(wr_byte(i_sfr, ADDR_EGP, {1'b0, ext_rising_edge_enable}));
      ext_falling_edge_enable <= 7'(wr_byte(i_sfr, ADDR_EGN, {1'b0, ext_falling_edge_enable}));
    end
  end

  // Pin 0 is P120, pins 1-4 P30-P33, pin 5 P16, pin 6 P140
  ipe_edge_detect #(
    .N(NUM_EXT)
  ) u_edge (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_pin(i_ext_pin),
    .i_rise_sel(ext_rising_edge_enable),
    .i_fall_sel(ext_falling_edge_enable),
    .o_edge(o_ext_edge)
  );

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  // The core stacks o_psw in the acknowledge or break cycle, before update
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      psw <= RST_PSW;
    end else if (i_core.ack) begin
      psw[PSW_IE_BIT] <= 1'b0;
      psw[PSW_ISP_BIT] <= pr_vec[o_irq.src];
    end else if (i_core.software_break_instr) begin
      psw[PSW_IE_BIT] <= 1'b0;
    end else if (i_core.restore) begin
      psw <= i_core.stack_psw;
    end else if (i_core.ei) begin
      psw[PSW_IE_BIT] <= 1'b1;
    end else if (i_core.di) begin
      psw[PSW_IE_BIT] <= 1'b0;
    end else begin
      psw <= wr_byte(i_sfr, ADDR_PSW, psw);
    end
  end
  assign o_psw = psw;

  // ----------------------------------------------------------------
  // Arbiter
  // ----------------------------------------------------------------
  assign cand = i_req_flags & ~i_mask_flags;
  assign cand_hi = cand & ~pr_vec;
  assign cand_lo = cand & pr_vec;
  assign pick_hi = first_set(cand_hi);
  assign pick_lo = first_set(cand_lo);

  always_comb begin
    next_irq = '0;
    if (psw[PSW_IE_BIT] && !i_core.ack && !i_core.software_break_instr) begin
      if (pick_hi[SRC_W]) begin
        next_irq = {1'b1, 1'b0, pick_hi[SRC_W-1:0]};
      end else if (pick_lo[SRC_W] && psw[PSW_ISP_BIT]) begin
        next_irq = {1'b1, 1'b1, pick_lo[SRC_W-1:0]};
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_irq <= '0;
    end else begin
      o_irq <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_sfr_rdata <= 16'h0000;
    end else if (i_sfr.rd) begin
      o_sfr_rdata[7:0] <= rd_byte(i_sfr.addr, priority_flags_0_low, priority_flags_0_high, priority_flags_1_low, priority_flags_1_high, ext_rising_edge_enable, ext_falling_edge_enable, psw);
      o_sfr_rdata[15:8] <= i_sfr.word ?
        rd_byte(i_sfr.addr + 16'h0001, priority_flags_0_low, priority_flags_0_high, priority_flags_1_low, priority_flags_1_high, ext_rising_edge_enable, ext_falling_edge_enable, psw) : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_reset_values;
    @(posedge i_clk_sys) i_rst |=> (psw == RST_PSW) && (pr_vec == '1) && (ext_rising_edge_enable == '0)
      && (ext_falling_edge_enable == '0) && !o_irq.valid;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad reset value");

  sequence s_ack;
    i_core.ack ##0 (o_irq.prio == pr_vec[o_irq.src]);
  endsequence
  property p_ack_psw;
    @(posedge i_clk_sys) disable iff (i_rst)
      s_ack |=> !psw[PSW_IE_BIT] && (psw[PSW_ISP_BIT] == $past(o_irq.prio));
  endproperty
  a_ack_psw: assert property (p_ack_psw) else $error("acknowledge did not update psw");

  property p_brk_clears_ie;
    @(posedge i_clk_sys) disable iff (i_rst) (i_core.software_break_instr && !i_core.ack) |=> !psw[PSW_IE_BIT];
  endproperty
  a_brk_clears_ie: assert property (p_brk_clears_ie) else $error("break left ie set");

  property p_ei_sets;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_core.ei && !i_core.ack && !i_core.software_break_instr && !i_core.restore) |=> psw[PSW_IE_BIT];
  endproperty
  a_ei_sets: assert property (p_ei_sets) else $error("enable instruction lost");

  property p_restore;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_core.restore && !i_core.ack && !i_core.software_break_instr) |=> (psw == $past(i_core.stack_psw));
  endproperty
  a_restore: assert property (p_restore) else $error("status word not restored");

  property p_grant_needs_ie;
    @(posedge i_clk_sys) disable iff (i_rst)
      o_irq.valid |-> $past(psw[PSW_IE_BIT]) && (($past(cand) & (NUM_SRC'(1) << o_irq.src)) != '0);
  endproperty
  a_grant_needs_ie: assert property (p_grant_needs_ie) else $error("grant without enable");

  property p_high_wins;
    @(posedge i_clk_sys) disable iff (i_rst)
      (o_irq.valid && o_irq.prio) |-> ($past(cand_hi) == '0) && $past(psw[PSW_ISP_BIT]);
  endproperty
  a_high_wins: assert property (p_high_wins) else $error("low granted over high");

  property p_word_write;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_sfr.wr && i_sfr.word && i_sfr.addr == ADDR_PRIORITY_FLAGS_0_LOW) |=> ({priority_flags_0_high, priority_flags_0_low} == $past(i_sfr.wdata));
  endproperty
  a_word_write: assert property (p_word_write) else $error("word write failed");

endmodule

// *** test/ipe_core_model.sv ***
/*
  Behavioural CPU core facing the interrupt block: takes grants, stacks
  and restores the status word, issues status word instructions.
  Assumes the block samples its core strobes on the rising clock edge.
*/
`timescale 1ns/1ps
module ipe_core_model (
  input wire logic i_clk_sys,
  input ipe_pkg::ipe_irq_s i_irq,
  input wire logic [7:0] i_psw,
  input wire logic i_en,
  input wire logic [3:0] i_lat,
  output ipe_pkg::ipe_core_s o_core
);
  import ipe_pkg::*;
  logic [7:0] stack[$];
  int wait_n = 0;
  initial o_core = '0;
  // ----------------------------------------------------------------
  // Grant acceptance, prompt or slow
  // ----------------------------------------------------------------
  always @(negedge i_clk_sys) begin
    if (o_core.ack || !i_en || !i_irq.valid) begin
      o_core.ack <= 1'b0;
      wait_n = 0;
    end else if (wait_n >= int'(i_lat)) begin
      o_core.ack <= 1'b1;
      stack.push_back(i_psw);
    end else begin
      wait_n++;
    end
  end
  // ----------------------------------------------------------------
  // Instructions: 0 break, 1 enable, 2 disable, 3 return
  // ----------------------------------------------------------------
  task automatic op(input int k);
    @(negedge i_clk_sys);
    o_core.software_break_instr <= (k == 0);
    o_core.ei <= (k == 1);
    o_core.di <= (k == 2);
    o_core.restore <= (k == 3);
    if (k == 0) begin
      stack.push_back(i_psw);
    end
    if (k == 3) begin
      o_core.stack_psw <= stack.pop_back();
    end
    @(negedge i_clk_sys);
    o_core.software_break_instr <= 1'b0;
    o_core.ei <= 1'b0;
    o_core.di <= 1'b0;
    o_core.restore <= 1'b0;
    o_core.stack_psw <= ~o_core.stack_psw;
  endtask
endmodule

// *** test/tb_interrupt_priority_edge_psw.sv ***
/*
  Self-checking bench for the priority, edge select and status word block.
  Assumes the core model and the design package compiled before it.
*/
`timescale 1ns/1ps
module tb_interrupt_priority_edge_psw;
  import ipe_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst;
  ipe_sfr_req_s sfr;
  logic [15:0] rdata;
  ipe_core_s core;
  logic [7:0] psw;
  logic [23:0] req;
  logic [23:0] mask;
  ipe_irq_s irq;
  logic [6:0] pin;
  logic [6:0] edge_o;
  logic [6:0] acc;
  logic en;
  logic [3:0] lat;
  int bad_count = 0;
  int n_checks = 0;
  int cnt;
  logic [15:0] p0, p1;
  logic [7:0] m_psw, saved;
  ipe_irq_s e;
  always #2.5 i_clk_sys = ~i_clk_sys;
  ipe_ctrl i_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sfr(sfr), .o_sfr_rdata(rdata),
    .i_core(core), .o_psw(psw), .i_req_flags(req), .i_mask_flags(mask), .o_irq(irq),
    .i_ext_pin(pin), .o_ext_edge(edge_o));
  ipe_core_model i_cpu (.i_clk_sys(i_clk_sys), .i_irq(irq), .i_psw(psw), .i_en(en),
    .i_lat(lat), .o_core(core));
  // ----------------------------------------------------------------
  // Reference arbiter and shared tasks
  // ----------------------------------------------------------------
  function automatic ipe_irq_s arb(input logic [23:0] pr, input logic [7:0] ps);
    arb = '0;
    for (int l = 0; l < 2; l++)
      for (int i = 0; i < NUM_SRC; i++)
        if (ps[PSW_IE_BIT] && !arb.valid && req[i] && !mask[i] && pr[i] == l
            && (l == 0 || ps[PSW_ISP_BIT])) begin
          arb = {1'b1, l[0], 5'(i)};
        end
  endfunction
  task automatic chk_val(input string nm, input logic [15:0] x, input logic [15:0] g);
    n_checks++;
    if (g !== x) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic sfr_cyc(input logic r, input logic [15:0] a, input logic [15:0] d,
                         input logic w, input logic b);
    @(negedge i_clk_sys);
    sfr <= {r, ~r, w, b, d[10:8], d[0], a, d};
    @(negedge i_clk_sys);
    sfr.rd <= 1'b0;
    sfr.wr <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [15:0] a, input logic w,
                        input logic [15:0] x);
    sfr_cyc(1'b1, a, 16'h0000, w, 1'b0);
    chk_val(nm, x, rdata);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    i_rst = 1'b1;
    sfr = '0;
    req = '0;
    mask = '1;
    pin = '0;
    en = 1'b0;
    lat = '0;
    void'($urandom(48));
    repeat (16) @(negedge i_clk_sys);
    i_rst <= 1'b0;
    m_psw = RST_PSW;
    rd_chk("prio word 0", ADDR_PRIORITY_FLAGS_0_LOW, 1'b1, 16'hFFFF);
    rd_chk("prio word 1", ADDR_PRIORITY_FLAGS_1_LOW, 1'b1, 16'hFFFF);
    rd_chk("rise enable", ADDR_EGP, 1'b0, 16'h0000);
    rd_chk("fall enable", ADDR_EGN, 1'b0, 16'h0000);
    rd_chk("unmapped", 16'hFF00, 1'b0, 16'h0000);
    chk_val("status word", {8'h00, m_psw}, {8'h00, psw});
    $display("test reset done");
    sfr_cyc(1'b0, ADDR_PSW, 16'h0042, 1'b0, 1'b0);
    rd_chk("status read", ADDR_PSW, 1'b0, 16'h0042);
    sfr_cyc(1'b0, ADDR_PSW, 16'h0701, 1'b0, 1'b1);
    chk_val("status word", 16'h00C2, {8'h00, psw});
    i_cpu.op(0);
    chk_val("status word", 16'h0042, {8'h00, psw});
    i_cpu.op(3);
    chk_val("status word", 16'h00C2, {8'h00, psw});
    i_cpu.op(2);
    m_psw = 8'h42;
    chk_val("status word", {8'h00, m_psw}, {8'h00, psw});
    $display("test status word done");
    sfr_cyc(1'b0, ADDR_EGP, 16'h007F, 1'b0, 1'b0);
    rd_chk("rise enable", ADDR_EGP, 1'b0, 16'h007F);
    sfr_cyc(1'b0, ADDR_EGN, 16'h0301, 1'b0, 1'b1);
    rd_chk("fall enable", ADDR_EGN, 1'b0, 16'h0008);
    for (int k = 0; k < NUM_EXT; k++)
      for (int m = 0; m < 4; m++) begin
        sfr_cyc(1'b0, ADDR_EGP, 16'(m[1]) << k, 1'b0, 1'b0);
        sfr_cyc(1'b0, ADDR_EGN, 16'(m[0]) << k, 1'b0, 1'b0);
        for (int s = 0; s < 2; s++) begin
          cnt = 0;
          acc = '0;
          @(negedge i_clk_sys);
          pin[k] <= ~pin[k];
          repeat (8) begin
            @(negedge i_clk_sys);
            cnt += $countones(edge_o);
            acc |= edge_o;
          end
          chk_val("edge count", 16'(s == 0 ? m[1] : m[0]), 16'(cnt));
          chk_val("edge pin", 16'(cnt > 0) << k, {9'h000, acc});
        end
      end
    sfr_cyc(1'b0, ADDR_EGP, 16'h0000, 1'b0, 1'b0);
    sfr_cyc(1'b0, ADDR_EGN, 16'h0000, 1'b0, 1'b0);
    $display("test edges done");
    for (int r = 0; r < 12; r++) begin
      p0 = 16'($urandom());
      p1 = 16'($urandom()) | 16'hFE80;
      sfr_cyc(1'b0, ADDR_PRIORITY_FLAGS_0_LOW, p0, 1'b1, 1'b0);
      sfr_cyc(1'b0, ADDR_PRIORITY_FLAGS_1_LOW, p1, 1'b1, 1'b0);
      sfr_cyc(1'b0, ADDR_PRIORITY_FLAGS_0_HIGH, {5'h00, r[2:0], 7'h00, r[3]}, 1'b0, 1'b1);
      p0[8 + r[2:0]] = r[3];
      rd_chk("prio word 0", ADDR_PRIORITY_FLAGS_0_LOW, 1'b1, p0);
      rd_chk("prio high 1", ADDR_PRIORITY_FLAGS_1_HIGH, 1'b0, {8'h00, p1[15:8]});
      req <= 24'($urandom() & $urandom() & $urandom());
      mask <= 24'($urandom() & $urandom());
      lat <= 4'($urandom_range(7));
      i_cpu.op(1);
      m_psw[PSW_IE_BIT] = 1'b1;
      repeat (2) @(negedge i_clk_sys);
      e = arb({p1[8], p1[6:0], p0}, m_psw);
      chk_val("grant", 16'(e.valid ? e : 7'(e.valid)), 16'(irq.valid ? irq : 7'(irq.valid)));
      if (e.valid) begin
        en <= 1'b1;
        for (int t = 0; t < 20 && !core.ack; t++) @(negedge i_clk_sys);
        en <= 1'b0;
        saved = m_psw;
        m_psw[PSW_IE_BIT] = 1'b0;
        m_psw[PSW_ISP_BIT] = e.prio;
        chk_val("status word", {8'h00, m_psw}, {8'h00, psw});
        i_cpu.op(1);
        m_psw[PSW_IE_BIT] = 1'b1;
        repeat (2) @(negedge i_clk_sys);
        e = arb({p1[8], p1[6:0], p0}, m_psw);
        chk_val("nested grant", 16'(e.valid), 16'(irq.valid));
        i_cpu.op(2);
        i_cpu.op(3);
        m_psw = saved;
        chk_val("status word", {8'h00, m_psw}, {8'h00, psw});
      end
    end
    $display("test arbitration done");
    end_sim();
  end
endmodule
